/* rtl/scan_pkg.sv */
package scan_pkg;

  // Clock and timing figures
  localparam int CLK_PERIOD_NS = 4;
  localparam int HSETUP_NS     = 100;  // Horizontal settle before first vertical
  localparam int PULSE_NS      = 200;  // Each vertical pulse
  localparam int GAP_NS        = 100;  // Dead time between phases
  localparam int WINDOW_NS     = 400;  // Response window length

  // Least times round up, never below one cycle
  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int HSETUP_CYC = ns2cyc(HSETUP_NS);
  localparam int PULSE_CYC  = ns2cyc(PULSE_NS);
  localparam int GAP_CYC    = ns2cyc(GAP_NS);
  localparam int WINDOW_CYC = ns2cyc(WINDOW_NS);
  localparam int CNT_W      = 8;

  // Geometry
  localparam int ROWS         = 16;
  localparam int COLS         = 8;
  localparam int VERTS        = 16;
  localparam int DRV_SECTIONS = 4;
  localparam int DRV_WIDTH    = 4;
  localparam int DET_SECTIONS = 8;
  localparam int DET_PER_PORT = 4;
  localparam int DET_WIDTH    = 16;
  localparam int HCNT_W       = 5;

  // Scan address layout: row field above column field
  localparam int ADDR_W      = 7;
  localparam int COL_LSB     = 0;
  localparam int COL_W       = 3;
  localparam int ROW_LSB     = 3;
  localparam int ROW_W       = 4;
  localparam int ORDER_W     = 4;

  // Detector bits routed through control
  localparam int STATUS_LSB  = 2;
  localparam int STATUS_W    = 4;

  // Orders that substitute status for detector bits
  localparam logic [ORDER_W-1:0] ORDER_STATUS_A = 4'hE;
  localparam logic [ORDER_W-1:0] ORDER_STATUS_B = 4'hF;

  typedef enum {S_IDLE, S_HSEL, S_NEG, S_GAP, S_POS, S_OPEN, S_WINDOW} scan_state_t;

  function automatic logic is_status_order(input logic [ORDER_W-1:0] code);
    return (code == ORDER_STATUS_A) || (code == ORDER_STATUS_B);
  endfunction

  function automatic logic [HCNT_W-1:0] count_ones16(input logic [ROWS-1:0] v);
    logic [HCNT_W-1:0] n;
    n = '0;
    for (int i = 0; i < ROWS; i++) begin
      n = n + {{(HCNT_W-1){1'b0}}, v[i]};
    end
    return n;
  endfunction

  function automatic logic is_one_hot(input logic [ROWS-1:0] v);
    return count_ones16(v) == 5'h01;
  endfunction

endpackage

/* rtl/vdrv_if.sv */
`timescale 1ns/10ps
interface vdrv_if;
  import scan_pkg::*;
  logic [DRV_WIDTH-1:0] col_dec;
  logic                 tim_neg;
  logic                 tim_pos;
  logic [DRV_WIDTH-1:0] pos_out;
  logic [DRV_WIDTH-1:0] neg_out;
  logic                 sel_any;

  modport ctl (output col_dec, output tim_neg, output tim_pos,
               input pos_out, input neg_out, input sel_any);
  modport drv (input col_dec, input tim_neg, input tim_pos,
               output pos_out, output neg_out, output sel_any);
endinterface

/* rtl/interrogate_vertical_driver.sv */
`timescale 1ns/10ps
module interrogate_vertical_driver
  import scan_pkg::*;
(
  vdrv_if.drv bus  // Decoder and timing in, drives out
);

  always_comb begin
    bus.pos_out = bus.col_dec & {DRV_WIDTH{bus.tim_pos}};
    bus.neg_out = bus.col_dec & {DRV_WIDTH{bus.tim_neg}};
    bus.sel_any = |bus.col_dec;
  end

endmodule // interrogate_vertical_driver

/* rtl/ferroid_scan_controller.sv */
// Operation
// - The scan address decodes into exactly one of 16 rows and exactly one of 8 columns.
// - One of two half enables, chosen by scanner half, starts the interrogation sequence.
// - Each interrogation drives the negative vertical, then the positive, then opens the response window.
// - Window-open and window-close pulses bound the span in which responses are accepted.
// - The matrix is sixteen 4x4 sections; the first four drive rows and report how many are selected.
// - The row is driven first, then the negative vertical pulse, then the positive one.
// - Each vertical driver section gates four column outputs with two timing signals into four pos and four neg.
// - Column outputs fan out to two driver pairs; the accessed half picks which timing pair is used.
// - Driver and row sections form one-hot checks reported to control, using only the first driver's check.
// - Each detector section returns 16 bits; sections 0-3 share the low port, 4-7 the high port.
// - Detector bits 2 to 5 pass through control and are replaced by status on designated orders.
// - Test current injected into a detector section forces all its 16 outputs to zero.
// - The scanner reads out up to eight blocks of 512 ferroid points each.
`timescale 1ns/10ps
module ferroid_scan_controller
  import scan_pkg::*;
(
  input  wire logic                                  mclk,              // 250 MHz clock
  input  wire logic                                  reset,             // Sync reset, high
  input  wire logic [ADDR_W-1:0]                     scan_addr,         // Row and column address
  input  wire logic [ORDER_W-1:0]                    order_code,        // Order from controller
  input  wire logic                                  enable_low,        // Low half enable
  input  wire logic                                  enable_high,       // High half enable
  input  wire logic [DET_SECTIONS-1:0][DET_WIDTH-1:0] det_raw,           // Detector readout lines
  input  wire logic [DET_SECTIONS-1:0]               test_inject,       // Test current per section
  output logic      [ROWS-1:0]                       row_sel,           // Horizontal drives
  output logic      [VERTS-1:0]                      pos_vert,          // Positive vertical drives
  output logic      [VERTS-1:0]                      neg_vert,          // Negative vertical drives
  output logic      [HCNT_W-1:0]                     horiz_count,       // Rows selected now
  output logic                                       window_open_pulse, // Window start
  output logic                                       window_close_pulse,// Window end
  output logic      [DET_WIDTH-1:0]                  port_low,          // Sections 0-3 word
  output logic      [DET_WIDTH-1:0]                  port_high,         // Sections 4-7 word
  output logic                                       sel_check_ok,      // One-hot checks good
  output logic                                       busy               // Sequence running
);

  localparam int A_PULSE = PULSE_CYC;
  localparam int A_GAP   = GAP_CYC;
  localparam int A_WIN   = WINDOW_CYC;

  scan_state_t          st_reg, st_next;
  logic [CNT_W-1:0]     cnt_reg, cnt_next;
  logic [ROWS-1:0]      row_reg, row_next;
  logic [COLS-1:0]      col_reg, col_next;
  logic                 half_reg, half_next;
  logic [ORDER_W-1:0]   order_reg, order_next;
  logic                 tneg_reg, tneg_next;
  logic                 tpos_reg, tpos_next;
  logic                 wopen_reg, wopen_next;
  logic                 wclose_reg, wclose_next;
  logic [DET_WIDTH-1:0] cap_lo_reg, cap_lo_next;
  logic [DET_WIDTH-1:0] cap_hi_reg, cap_hi_next;
  logic [DET_WIDTH-1:0] plo_reg, plo_next;
  logic [DET_WIDTH-1:0] phi_reg, phi_next;
  logic [VERTS-1:0]     pos_reg, pos_next;
  logic [VERTS-1:0]     neg_reg, neg_next;
  logic [HCNT_W-1:0]    hcnt_reg, hcnt_next;
  logic                 chk_reg, chk_next;
  logic                 busy_reg, busy_next;
  logic [STATUS_W-1:0]  status;
  logic [DET_WIDTH-1:0] word_lo, word_hi;
  logic [VERTS-1:0]     drv_pos, drv_neg;
  logic [DRV_SECTIONS-1:0] drv_any;
  logic                 start;

  // Vertical driver sections: pair 0-1 serves low half, pair 2-3 high half
  vdrv_if vd [DRV_SECTIONS] ();
  for (genvar d = 0; d < DRV_SECTIONS; d++) begin : g_drv
    assign vd[d].col_dec = col_reg[(d % 2)*DRV_WIDTH +: DRV_WIDTH];
    assign vd[d].tim_neg = tneg_reg & (half_reg == 1'(d / 2));
    assign vd[d].tim_pos = tpos_reg & (half_reg == 1'(d / 2));
    assign drv_pos[d*DRV_WIDTH +: DRV_WIDTH] = vd[d].pos_out;
    assign drv_neg[d*DRV_WIDTH +: DRV_WIDTH] = vd[d].neg_out;
    assign drv_any[d] = vd[d].sel_any;
    interrogate_vertical_driver u_drv (.bus(vd[d].drv));
  end

  // Detector sections onto the two shared ports
  always_comb begin
    word_lo = '0;
    word_hi = '0;
    for (int k = 0; k < DET_PER_PORT; k++) begin
      word_lo = word_lo | (det_raw[k] & ~{DET_WIDTH{test_inject[k]}});
      word_hi = word_hi | (det_raw[k+DET_PER_PORT] & ~{DET_WIDTH{test_inject[k+DET_PER_PORT]}});
    end
  end

  // Check from first driver section: some decoder output feeding it or its partner, not both
  assign status = {chk_reg, half_reg, is_one_hot(row_reg), drv_any[0] ^ drv_any[1]};
  assign start  = (enable_low ^ enable_high);

  always_comb begin
    st_next     = st_reg;
    cnt_next    = cnt_reg;
    row_next    = row_reg;
    col_next    = col_reg;
    half_next   = half_reg;
    order_next  = order_reg;
    cap_lo_next = cap_lo_reg;
    cap_hi_next = cap_hi_reg;
    plo_next    = plo_reg;
    phi_next    = phi_reg;
    wclose_next = 1'b0;
    if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 8'h01;
    end
    unique case (st_reg)
      S_IDLE: begin
        if (start) begin
          row_next   = ROWS'(1) << scan_addr[ROW_LSB +: ROW_W];
          col_next   = COLS'(1) << scan_addr[COL_LSB +: COL_W];
          half_next  = enable_high;
          order_next = order_code;
          cnt_next   = CNT_W'(HSETUP_CYC - 1);
          st_next    = S_HSEL;
        end
      end
      S_HSEL: begin
        if (cnt_reg == '0) begin
          cnt_next = CNT_W'(PULSE_CYC - 1);
          st_next  = S_NEG;
        end
      end
      S_NEG: begin
        if (cnt_reg == '0) begin
          cnt_next = CNT_W'(GAP_CYC - 1);
          st_next  = S_GAP;
        end
      end
      S_GAP: begin
        if (cnt_reg == '0) begin
          cnt_next = CNT_W'(PULSE_CYC - 1);
          st_next  = S_POS;
        end
      end
      S_POS: begin
        if (cnt_reg == '0) begin
          cnt_next = CNT_W'(GAP_CYC - 1);
          st_next  = S_OPEN;
        end
      end
      S_OPEN: begin
        if (cnt_reg == '0) begin
          cnt_next    = CNT_W'(WINDOW_CYC - 1);
          cap_lo_next = '0;
          cap_hi_next = '0;
          st_next     = S_WINDOW;
        end
      end
      S_WINDOW: begin
        cap_lo_next = cap_lo_reg | word_lo;
        cap_hi_next = cap_hi_reg | word_hi;
        if (cnt_reg == '0) begin
          wclose_next = 1'b1;
          plo_next    = cap_lo_next;
          phi_next    = cap_hi_next;
          if (is_status_order(order_reg)) begin
            plo_next[STATUS_LSB +: STATUS_W] = status;
            phi_next[STATUS_LSB +: STATUS_W] = status;
          end
          row_next = '0;
          col_next = '0;
          st_next  = S_IDLE;
        end
      end
    endcase
    tneg_next  = (st_next == S_NEG);
    tpos_next  = (st_next == S_POS);
    wopen_next = (st_next == S_WINDOW) && (st_reg != S_WINDOW);
    pos_next   = drv_pos;
    neg_next   = drv_neg;
    hcnt_next  = count_ones16(row_next);
    chk_next   = is_one_hot(row_reg) && (drv_any[0] ^ drv_any[1]);
    busy_next  = (st_next != S_IDLE);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_reg     <= S_IDLE;
      cnt_reg    <= '0;
      row_reg    <= '0;
      col_reg    <= '0;
      half_reg   <= 1'b0;
      order_reg  <= '0;
      tneg_reg   <= 1'b0;
      tpos_reg   <= 1'b0;
      wopen_reg  <= 1'b0;
      wclose_reg <= 1'b0;
      cap_lo_reg <= '0;
      cap_hi_reg <= '0;
      plo_reg    <= '0;
      phi_reg    <= '0;
      pos_reg    <= '0;
      neg_reg    <= '0;
      hcnt_reg   <= '0;
      chk_reg    <= 1'b0;
      busy_reg   <= 1'b0;
    end else begin
      st_reg     <= st_next;
      cnt_reg    <= cnt_next;
      row_reg    <= row_next;
      col_reg    <= col_next;
      half_reg   <= half_next;
      order_reg  <= order_next;
      tneg_reg   <= tneg_next;
      tpos_reg   <= tpos_next;
      wopen_reg  <= wopen_next;
      wclose_reg <= wclose_next;
      cap_lo_reg <= cap_lo_next;
      cap_hi_reg <= cap_hi_next;
      plo_reg    <= plo_next;
      phi_reg    <= phi_next;
      pos_reg    <= pos_next;
      neg_reg    <= neg_next;
      hcnt_reg   <= hcnt_next;
      chk_reg    <= chk_next;
      busy_reg   <= busy_next;
    end
  end

  assign row_sel            = row_reg;
  assign pos_vert           = pos_reg;
  assign neg_vert           = neg_reg;
  assign horiz_count        = hcnt_reg;
  assign window_open_pulse  = wopen_reg;
  assign window_close_pulse = wclose_reg;
  assign port_low           = plo_reg;
  assign port_high          = phi_reg;
  assign sel_check_ok       = chk_reg;
  assign busy               = busy_reg;

  // Checks
  sequence neg_then_pos_s;
    (!tneg_reg) ##A_GAP tpos_reg;
  endsequence

  start_seq_a: assert property (@(posedge mclk) disable iff (reset)
    (st_reg == S_IDLE && start) |=> (row_sel != '0) && busy)
    else $error("enable did not start a scan");

  row_onehot_a: assert property (@(posedge mclk) disable iff (reset)
    (row_sel != '0) |-> $onehot(row_sel) && $onehot(col_reg))
    else $error("row or column select not one-hot");

  phase_order_a: assert property (@(posedge mclk) disable iff (reset)
    $rose(tneg_reg) |-> ##A_PULSE neg_then_pos_s)
    else $error("negative then positive phase order broken");

  row_first_a: assert property (@(posedge mclk) disable iff (reset)
    $rose(tneg_reg) |-> (row_sel != '0) && $past(row_sel != '0))
    else $error("vertical pulse without prior row");

  open_after_pos_a: assert property (@(posedge mclk) disable iff (reset)
    $fell(tpos_reg) |-> ##[1:100] window_open_pulse)
    else $error("window did not open after positive phase");

  window_len_a: assert property (@(posedge mclk) disable iff (reset)
    window_open_pulse |-> ##A_WIN window_close_pulse)
    else $error("window close pulse mistimed");

  hcount_a: assert property (@(posedge mclk) disable iff (reset)
    $rose(busy) |-> horiz_count == 5'h01)
    else $error("horizontal count wrong after selection");

  vert_half_a: assert property (@(posedge mclk) disable iff (reset)
    (pos_vert != '0 || neg_vert != '0) |->
      (half_reg ? (pos_vert[7:0] == 8'h00) : (pos_vert[15:8] == 8'h00)) && ((pos_vert & neg_vert) == '0))
    else $error("vertical drive on wrong half");

  status_sub_a: assert property (@(posedge mclk) disable iff (reset)
    (window_close_pulse && is_status_order(order_reg)) |->
      port_low[STATUS_LSB +: STATUS_W] == $past(status))
    else $error("status not substituted on status order");

  clear_idle_a: assert property (@(posedge mclk) disable iff (reset)
    window_close_pulse |-> (row_sel == '0) && !busy ##1 (pos_vert == '0))
    else $error("selections not cleared after window");

endmodule // ferroid_scan_controller

/* tb/frame_io_controller_model.sv */
`timescale 1ns/10ps
module frame_io_controller_model
  import scan_pkg::*;
(
  input  wire logic                 mclk,               // Clock
  input  wire logic                 window_open_pulse,  // Window start
  input  wire logic                 window_close_pulse, // Window end
  input  wire logic [DET_WIDTH-1:0] port_low,           // Low port word
  input  wire logic [DET_WIDTH-1:0] port_high,          // High port word
  output logic      [ADDR_W-1:0]    scan_addr,          // Address to scanner
  output logic      [ORDER_W-1:0]   order_code,         // Order to scanner
  output logic                      enable_low,         // Low half enable
  output logic                      enable_high,        // High half enable
  output logic      [DET_WIDTH-1:0] got_low,            // Accepted low word
  output logic      [DET_WIDTH-1:0] got_high            // Accepted high word
);
  logic in_window;

  initial begin
    scan_addr   = 7'h00;
    order_code  = 4'h0;
    enable_low  = 1'b0;
    enable_high = 1'b0;
    got_low     = 16'h0000;
    got_high    = 16'h0000;
    in_window   = 1'b0;
  end

  // Responses taken only inside the open/close span
  always @(posedge mclk) begin
    if (window_open_pulse) begin
      in_window <= 1'b1;
    end
    if (window_close_pulse && in_window) begin
      in_window <= 1'b0;
      got_low   <= port_low;
      got_high  <= port_high;
    end
  end

  // One-cycle enable; address and order garbled once taken
  task automatic issue(input logic lo, input logic hi, input logic [ADDR_W-1:0] a, input logic [ORDER_W-1:0] o);
    @(posedge mclk);
    #1;
    scan_addr   = a;
    order_code  = o;
    enable_low  = lo;
    enable_high = hi;
    @(posedge mclk);
    #1;
    enable_low  = 1'b0;
    enable_high = 1'b0;
    scan_addr   = ~a;
    order_code  = ~o;
  endtask
endmodule // frame_io_controller_model

/* tb/ferroid_scan_controller_tb.sv */
`timescale 1ns/10ps
module ferroid_scan_controller_tb;
  import scan_pkg::*;
  logic                               mclk, reset, enable_low, enable_high;
  logic                               window_open_pulse, window_close_pulse, sel_check_ok, busy;
  logic [ADDR_W-1:0]                  scan_addr;
  logic [ORDER_W-1:0]                 order_code;
  logic [DET_SECTIONS-1:0][DET_WIDTH-1:0] det_raw;
  logic [DET_SECTIONS-1:0]            test_inject;
  logic [ROWS-1:0]                    row_sel;
  logic [VERTS-1:0]                   pos_vert, neg_vert;
  logic [HCNT_W-1:0]                  horiz_count;
  logic [DET_WIDTH-1:0]               port_low, port_high, got_low, got_high;
  int                                 bad_count, cmp_count, cyc;

  ferroid_scan_controller ferroid_scan_controller_inst (.mclk(mclk), .reset(reset), .scan_addr(scan_addr),
    .order_code(order_code), .enable_low(enable_low), .enable_high(enable_high), .det_raw(det_raw),
    .test_inject(test_inject), .row_sel(row_sel), .pos_vert(pos_vert), .neg_vert(neg_vert),
    .horiz_count(horiz_count), .window_open_pulse(window_open_pulse), .window_close_pulse(window_close_pulse),
    .port_low(port_low), .port_high(port_high), .sel_check_ok(sel_check_ok), .busy(busy));

  frame_io_controller_model frame_io_controller_model_inst (.mclk(mclk), .window_open_pulse(window_open_pulse),
    .window_close_pulse(window_close_pulse), .port_low(port_low), .port_high(port_high), .scan_addr(scan_addr),
    .order_code(order_code), .enable_low(enable_low), .enable_high(enable_high), .got_low(got_low),
    .got_high(got_high));

  task automatic wrap_up();
    if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk_w(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_b(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  // Wired-OR of one port's sections, status bits on status orders
  function automatic logic [15:0] exp_port(input bit hi, input bit half, input logic [3:0] ord);
    logic [15:0] w;
    w = 16'h0000;
    for (int k = 0; k < 4; k++) begin
      if (!test_inject[hi ? k + 4 : k]) w = w | det_raw[hi ? k + 4 : k];
    end
    if (ord == 4'hE || ord == 4'hF) w[5:2] = {1'b1, half, 1'b1, 1'b1};
    return w;
  endfunction

  task automatic run_scan(input bit half, input logic [3:0] row, input logic [2:0] col, input logic [3:0] ord);
    logic [15:0] rs;
    logic [15:0] vb;
    rs = 16'h0001 << row;
    vb = 16'h0001 << (half ? 8 + col : col);
    frame_io_controller_model_inst.issue(!half, half, {row, col}, ord);
    for (int n = 1; n <= 276; n++) begin
      @(posedge mclk);
      #1;
      chk_w(row_sel, n < 275 ? rs : 16'h0000, "row_sel");
      chk_w(neg_vert, (n >= 26 && n <= 75) ? vb : 16'h0000, "neg_vert");
      chk_w(pos_vert, (n >= 101 && n <= 150) ? vb : 16'h0000, "pos_vert");
      chk_b(window_open_pulse, n == 175, "open");
      chk_b(window_close_pulse, n == 275, "close");
      chk_b(busy, n < 275, "busy");
      chk_w({11'h000, horiz_count}, n < 275 ? 16'h0001 : 16'h0000, "horiz_count");
      if (n >= 100 && n <= 175) chk_b(sel_check_ok, 1'b1, "sel_check");
    end
    chk_w(port_low, exp_port(0, half, ord), "port_low");
    chk_w(port_high, exp_port(1, half, ord), "port_high");
    @(posedge mclk);
    #1;
    chk_w(got_low, exp_port(0, half, ord), "got_low");
    chk_w(got_high, exp_port(1, half, ord), "got_high");
  endtask

  task automatic test_sweep();
    for (int r = 0; r < 16; r++) begin
      run_scan(r[0], 4'(r), 3'(r) ^ 3'h5, 4'h0);
    end
  endtask

  task automatic test_inject_loop();
    test_inject = 8'h0F;
    run_scan(1'b1, 4'hF, 3'h7, 4'h3);
    test_inject = 8'h81;
    run_scan(1'b0, 4'h0, 3'h0, 4'hE);
    test_inject = 8'h00;
  endtask

  task automatic test_status();
    run_scan(1'b0, 4'h9, 3'h2, 4'hD);
    for (int h = 0; h < 2; h++) begin
      run_scan(h[0], 4'h9, 3'h2, 4'hE);
      run_scan(h[0], 4'h6, 3'h5, 4'hF);
    end
  endtask

  task automatic test_refuse();
    frame_io_controller_model_inst.issue(1'b1, 1'b1, 7'h2A, 4'h0);
    repeat (20) begin
      @(posedge mclk);
      #1;
      chk_b(busy, 1'b0, "busy both");
      chk_w(row_sel, 16'h0000, "row_sel both");
    end
  endtask

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 10000) begin
      bad_count++;
      $display("[ERR] %0t timeout", $time);
      wrap_up();
    end
  end

  initial begin
    reset       = 1'b1;
    test_inject = 8'h00;
    for (int k = 0; k < DET_SECTIONS; k++) det_raw[k] = 16'(16'h1111 * (k + 1));
    repeat (3) @(posedge mclk);
    #1;
    reset = 1'b0;
    test_sweep();
    test_inject_loop();
    test_status();
    test_refuse();
    wrap_up();
  end
endmodule // ferroid_scan_controller_tb
